/* File: logic/isw_pkg.sv */
// package: shared constants and carrier types for the interrupt and wake block
package isw_pkg;

  // ==========================================
  // widths and field layout
  localparam int TMR_W       = 8;              // timer count width
  localparam int PS_W        = 3;              // prescale select width
  localparam int PRE_W       = 8;              // prescaler counter width
  localparam int PC_W        = 9;              // program counter width

  localparam logic [7:0] TMR_WRAP  = 8'hff;    // last count before wrap to zero
  localparam logic [7:0] TMR_ZERO  = 8'h00;    // count after wrap
  localparam logic [7:0] PRE_ZERO  = 8'h00;    // cleared prescaler
  localparam logic [7:0] PRE_ONE   = 8'h01;    // prescaler step
  localparam logic [7:0] TMR_ONE   = 8'h01;    // timer step

  // ==========================================
  // logic cell control word, cleared at every reset
  typedef struct packed {
    logic cell_on;                             // cell enabled
    logic cell_rise_irq_enable;                // rising edge gate
    logic cell_fall_irq_enable;                // falling edge gate
  } isw_cell_ctl_type;

  localparam isw_cell_ctl_type CELL_CTL_RESET = '{1'b0, 1'b0, 1'b0};

  // core-facing enables from the control registers
  typedef struct packed {
    logic global_irq_enable;                   // master enable
    logic peripheral_irq_enable;               // peripheral group enable
    logic ext_pin_irq_enable;                  // external pin enable
    logic timer_irq_enable;                    // timer overflow enable
    logic cell_irq_enable;                     // logic cell enable
  } isw_enables_type;

  // timer option fields
  typedef struct packed {
    logic            ext_edge_select;          // 1 rising, 0 falling
    logic            prescaler_assign;         // 0 gives prescaler to timer
    logic [PS_W-1:0] prescale_select;          // ratio 1:2 .. 1:256
    logic            counter_mode;             // 1 counts external clock input
  } isw_option_type;

  // flags seen by software
  typedef struct packed {
    logic ext_pin_irq_flag;                    // external edge seen
    logic timer_overflow_flag;                 // timer wrapped
    logic cell_irq_flag;                       // logic cell edge seen
  } isw_flags_type;

endpackage

/* File: logic/isw_edge_sync.sv */
// three-stage pin synchroniser with agreement-qualified change output
`timescale 1ns/10ps
module isw_edge_sync (
  input  wire logic clk_sys,                   // instruction clock
  input  wire logic rst,                       // async reset, high
  input  wire logic pin_in,                    // asynchronous pin
  output logic      level_out,                 // filtered level
  output logic      rise_pulse,                // one cycle on rise
  output logic      fall_pulse                 // one cycle on fall
);

  logic [2:0] sync_reg;                        // stage 0 feeds stage 1 only
  logic [2:0] sync_next;                       // shifted samples
  logic       level_reg;                       // accepted level
  logic       level_next;                      // next accepted level
  logic       rise_reg;                        // registered rise
  logic       rise_next;                       // next rise
  logic       fall_reg;                        // registered fall
  logic       fall_next;                       // next fall

  // ==========================================
  // change accepted once stages 1 and 2 agree
  always_comb begin
    sync_next  = {sync_reg[1:0], pin_in};
    level_next = level_reg;
    rise_next  = 1'b0;
    fall_next  = 1'b0;
    if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
      level_next = sync_reg[2];
      rise_next  = sync_reg[2];
      fall_next  = ~sync_reg[2];
    end
  end

  // ==========================================
  // registers only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
      rise_reg  <= rise_next;
      fall_reg  <= fall_next;
    end
  end

  assign level_out  = level_reg;
  assign rise_pulse = rise_reg;
  assign fall_pulse = fall_reg;

endmodule

/* File: logic/isw_irq_wake.sv */
// interrupt sources, timer with prescaler, logic cell edges, vectoring and wake
`timescale 1ns/10ps
// How it works
// - wake only from clockless sources enabled beforehand
// - wake vectors if global enable, else continues
// - instruction after sleep runs before vector
// - external pin gives edge interrupt, enable gated
// - edge select: one rising, zero falling
// - valid edge sets flag; enables redirect
// - only return address pushed on entry
// - prescaler belongs to timer when assign zero
// - eight ratios 1:2 to 1:256
// - timer write clears hidden prescaler when assign zero
// - wrap from ff sets overflow flag
// - overflow flag cleared only by software
// - external count edge sampled at q2, q4 when assign one, only at q4 via prescaler
// - rise and fall detectors on cell output
// - gated cell edge sets cell flag
// - cell interrupt needs on plus cell and peripheral enables, global to vector
// - edge during clear keeps flag set
// - reset clears all registers, cell control included
module isw_irq_wake #(
  parameter int TMR_W = isw_pkg::TMR_W         // timer width
) (
  input  wire logic                      clk_sys,          // instruction clock
  input  wire logic                      rst,              // async reset, high
  input  wire logic                      q2_phase,         // q2 phase enable pulse
  input  wire logic                      q4_phase,         // q4 phase enable pulse
  input  wire logic                      ext_irq_pin,      // external interrupt pin
  input  wire logic                      timer_ext_clock_in, // external timer clock pin
  input  wire logic                      cell_out,         // logic cell output, same clock
  input  wire isw_pkg::isw_enables_type  enables,          // enable bits
  input  wire isw_pkg::isw_option_type   option,           // option fields
  input  wire isw_pkg::isw_cell_ctl_type cell_ctl_wdata,   // cell control write data
  input  wire logic                      cell_ctl_we,      // cell control write strobe
  input  wire isw_pkg::isw_flags_type    flag_clear,       // software flag clears, pulses
  input  wire logic                      timer_we,         // software write of timer
  input  wire logic [TMR_W-1:0]          timer_wdata,      // timer write data
  input  wire logic                      sleep_exec,       // core executes sleep
  input  wire logic                      instr_done,       // core retires an instruction
  input  wire logic                      vector_ack,       // core took the vector
  input  wire logic [isw_pkg::PC_W-1:0]  return_pc,        // address to resume at
  output logic                           sleeping,         // device in sleep
  output logic                           wake_pulse,       // one cycle at wake
  output logic                           vector_req,       // branch to vector
  output logic                           stack_push,       // push return pc, one cycle
  output logic [isw_pkg::PC_W-1:0]       stack_data,       // pushed return pc
  output isw_pkg::isw_flags_type         flags,            // interrupt flags
  output isw_pkg::isw_cell_ctl_type      cell_ctl,         // cell control register
  output logic [TMR_W-1:0]               timer_count_reg   // timer count
);

  typedef enum logic [1:0] {
    ISW_RUN,                                   // normal execution
    ISW_SLEEP,                                 // clock gated, waiting for wake
    ISW_POST                                   // running the instruction after sleep
  } isw_state_type;

  // ==========================================
  // pin synchronisers
  logic ext_rise;                              // pin rising, synced
  logic ext_fall;                              // pin falling, synced
  logic tck_level;                             // timer clock level, synced

  isw_edge_sync u_ext_sync (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_in     (ext_irq_pin),
    .level_out  (),
    .rise_pulse (ext_rise),
    .fall_pulse (ext_fall)
  );

  isw_edge_sync u_tck_sync (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_in     (timer_ext_clock_in),
    .level_out  (tck_level),
    .rise_pulse (),
    .fall_pulse ()
  );

  // ==========================================
  // state
  isw_state_type              state_reg;       // sleep state
  isw_state_type              state_next;      // next sleep state
  isw_pkg::isw_flags_type     flags_reg;       // sticky flags
  isw_pkg::isw_flags_type     flags_next;      // next flags
  isw_pkg::isw_cell_ctl_type  cell_ctl_reg;    // cell control
  isw_pkg::isw_cell_ctl_type  cell_ctl_next;   // next cell control
  logic [TMR_W-1:0]           tmr_reg;         // timer count
  logic [TMR_W-1:0]           tmr_next;        // next timer count
  logic [isw_pkg::PRE_W-1:0]  pre_reg;         // hidden prescaler count
  logic [isw_pkg::PRE_W-1:0]  pre_next;        // next prescaler count
  logic                       pre_out_reg;     // prescaler output sampled at q2/q4
  logic                       pre_out_next;    // next sample
  logic                       cell_prev_reg;   // cell output one clock ago
  logic                       vec_reg;         // vector request
  logic                       vec_next;        // next vector request
  logic                       push_reg;        // stack push
  logic                       push_next;       // next stack push
  logic [isw_pkg::PC_W-1:0]   sdata_reg;       // pushed pc
  logic [isw_pkg::PC_W-1:0]   sdata_next;      // next pushed pc
  logic                       wake_reg;        // wake pulse
  logic                       wake_next;       // next wake pulse
  logic                       sleep_reg;       // registered copy of the sleep state for the output

  // prescaler tap for ratio 1:2^(sel+1)
  function automatic logic pre_tap(input logic [isw_pkg::PRE_W-1:0] cnt,
                                   input logic [isw_pkg::PS_W-1:0]  sel);
    pre_tap = cnt[sel];
  endfunction

  // ==========================================
  // edge and interrupt terms
  logic ext_edge;                              // selected external edge
  logic cell_rise;                             // cell output rising
  logic cell_fall;                             // cell output falling
  logic cell_edge;                             // gated cell edge
  logic count_src;                             // raw count source level
  logic count_edge;                            // timer increment event
  logic tmr_wrap;                              // timer wraps this cycle
  logic ext_pend;                              // external pending and enabled
  logic tmr_pend;                              // timer pending and enabled
  logic cell_pend;                             // cell pending and enabled
  logic irq_pend;                              // any enabled interrupt
  logic wake_src;                              // sleep-capable source pending

  always_comb begin
    ext_edge  = option.ext_edge_select ? ext_rise : ext_fall;
    cell_rise = cell_out & ~cell_prev_reg;
    cell_fall = ~cell_out & cell_prev_reg;
    cell_edge = cell_ctl_reg.cell_on &
                ((cell_rise & cell_ctl_reg.cell_rise_irq_enable) |
                 (cell_fall & cell_ctl_reg.cell_fall_irq_enable));
    count_src = option.counter_mode ? tck_level : 1'b1;
    if (option.prescaler_assign == 1'b0) begin
      count_edge = (q2_phase | q4_phase) &
                   pre_tap(pre_reg, option.prescale_select) & ~pre_out_reg;
    end else begin
      count_edge = option.counter_mode ? ((q2_phase | q4_phase) & tck_level & ~pre_out_reg)
                                       : q4_phase;
    end
    count_edge = count_edge & (state_reg != ISW_SLEEP);
    tmr_wrap   = count_edge & (tmr_reg == isw_pkg::TMR_WRAP) & ~timer_we;
    ext_pend   = flags_reg.ext_pin_irq_flag & enables.ext_pin_irq_enable;
    tmr_pend   = flags_reg.timer_overflow_flag & enables.timer_irq_enable;
    cell_pend  = flags_reg.cell_irq_flag & enables.cell_irq_enable &
                 enables.peripheral_irq_enable;
    irq_pend   = ext_pend | tmr_pend | cell_pend;
    wake_src   = ext_pend | cell_pend;
  end

  // ==========================================
  // next-state for timer, flags, cell control
  always_comb begin
    pre_next      = pre_reg;
    pre_out_next  = pre_out_reg;
    tmr_next      = tmr_reg;
    flags_next    = flags_reg;
    cell_ctl_next = cell_ctl_reg;
    if (cell_ctl_we) begin
      cell_ctl_next = cell_ctl_wdata;
    end
    // prescaler counts q4 pulses, in counter mode only while tck_level high and pre_out_reg low; output sampled on q2 and q4
    if ((q2_phase | q4_phase) && state_reg != ISW_SLEEP) begin
      if (option.prescaler_assign == 1'b0) begin
        pre_out_next = pre_tap(pre_reg, option.prescale_select);
        if (option.counter_mode ? q4_phase & tck_level & ~pre_out_reg : q4_phase) begin
          pre_next = pre_reg + isw_pkg::PRE_ONE;
        end
      end else begin
        pre_out_next = count_src;
      end
    end
    if (count_edge) begin
      tmr_next = tmr_reg + TMR_W'(isw_pkg::TMR_ONE);
    end
    if (timer_we) begin
      tmr_next = timer_wdata;
      if (option.prescaler_assign == 1'b0) begin
        pre_next = isw_pkg::PRE_ZERO;
      end
    end
    // clears first, then sets so a same-cycle event wins
    if (flag_clear.ext_pin_irq_flag)    flags_next.ext_pin_irq_flag    = 1'b0;
    if (flag_clear.timer_overflow_flag) flags_next.timer_overflow_flag = 1'b0;
    if (flag_clear.cell_irq_flag)       flags_next.cell_irq_flag       = 1'b0;
    if (ext_edge)  flags_next.ext_pin_irq_flag    = 1'b1;
    if (tmr_wrap)  flags_next.timer_overflow_flag = 1'b1;
    if (cell_edge) flags_next.cell_irq_flag       = 1'b1;
  end

  // ==========================================
  // sleep, wake and vectoring sequence
  always_comb begin
    state_next = state_reg;
    vec_next   = vec_reg & ~vector_ack;
    push_next  = 1'b0;
    sdata_next = sdata_reg;
    wake_next  = 1'b0;
    unique case (state_reg)
      ISW_RUN: begin
        if (sleep_exec) begin
          state_next = ISW_SLEEP;
        end else if (irq_pend && enables.global_irq_enable && !vec_reg && instr_done) begin
          vec_next   = 1'b1;
          push_next  = 1'b1;
          sdata_next = return_pc;
        end
      end
      ISW_SLEEP: begin
        if (wake_src) begin
          state_next = ISW_POST;
          wake_next  = 1'b1;
        end
      end
      ISW_POST: begin
        if (instr_done) begin
          state_next = ISW_RUN;
          if (enables.global_irq_enable && irq_pend) begin
            vec_next   = 1'b1;
            push_next  = 1'b1;
            sdata_next = return_pc;
          end
        end
      end
    endcase
  end

  // ==========================================
  // registers only; reset clears cell control, selection logic lives elsewhere
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg     <= ISW_RUN;
      flags_reg     <= '0;
      cell_ctl_reg  <= isw_pkg::CELL_CTL_RESET;
      tmr_reg       <= '0;
      pre_reg       <= isw_pkg::PRE_ZERO;
      pre_out_reg   <= 1'b0;
      cell_prev_reg <= 1'b0;
      vec_reg       <= 1'b0;
      push_reg      <= 1'b0;
      sdata_reg     <= '0;
      wake_reg      <= 1'b0;
      sleep_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      flags_reg     <= flags_next;
      cell_ctl_reg  <= cell_ctl_next;
      tmr_reg       <= tmr_next;
      pre_reg       <= pre_next;
      pre_out_reg   <= pre_out_next;
      cell_prev_reg <= cell_out;
      vec_reg       <= vec_next;
      push_reg      <= push_next;
      sdata_reg     <= sdata_next;
      wake_reg      <= wake_next;
      sleep_reg     <= (state_next == ISW_SLEEP);               // tracks state_reg, but as a plain flop
    end
  end

  // outputs straight from flip-flops
  assign sleeping        = sleep_reg;
  assign wake_pulse      = wake_reg;
  assign vector_req      = vec_reg;
  assign stack_push      = push_reg;
  assign stack_data      = sdata_reg;
  assign flags           = flags_reg;
  assign cell_ctl        = cell_ctl_reg;
  assign timer_count_reg = tmr_reg;

endmodule

/* File: dv/isw_core_model.sv */
// core model: instruction phase pulses and vector acknowledge
`timescale 1ns/10ps
module isw_core_model (
  input  wire logic clk_sys,    // clock
  input  wire logic rst,        // reset, high
  input  wire logic ack_slow,   // answer after five cycles
  input  wire logic vector_req, // branch request
  output logic      q2_phase,   // q2 pulse
  output logic      q4_phase,   // q4 pulse
  output logic      vector_ack  // vector taken, one cycle
);
  logic [1:0] ph_reg;   // phase count
  logic [2:0] wait_reg; // ack delay count
  // ==========================================
  // four phases per instruction cycle
  assign q2_phase = (ph_reg == 2'h1);
  assign q4_phase = (ph_reg == 2'h3);
  // ack held off while slow, dropped once taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph_reg     <= 2'h0;
      wait_reg   <= 3'h0;
      vector_ack <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      if (vector_req && !vector_ack) begin
        vector_ack <= (wait_reg >= (ack_slow ? 3'h5 : 3'h0));
        wait_reg   <= wait_reg + 3'h1;
      end else begin
        vector_ack <= 1'b0;
        wait_reg   <= 3'h0;
      end
    end
  end
endmodule

/* File: dv/isw_irq_wake_asserts.sv */
// checker: port properties of the interrupt and wake block
`timescale 1ns/10ps
module isw_irq_wake_asserts #(
  parameter int TMR_W = isw_pkg::TMR_W // timer width
) (
  input wire logic                      clk_sys,        // clock
  input wire logic                      rst,            // reset
  input wire logic                      ext_irq_pin,    // pin
  input wire logic                      cell_out,       // cell out
  input wire isw_pkg::isw_enables_type  enables,        // enables
  input wire isw_pkg::isw_option_type   option,         // options
  input wire isw_pkg::isw_flags_type    flag_clear,     // clears
  input wire logic                      timer_we,       // timer write
  input wire logic                      vector_ack,     // ack
  input wire logic [isw_pkg::PC_W-1:0]  return_pc,      // pc
  input wire logic                      sleeping,       // asleep
  input wire logic                      vector_req,     // vector
  input wire logic                      stack_push,     // push
  input wire logic [isw_pkg::PC_W-1:0]  stack_data,     // pushed pc
  input wire isw_pkg::isw_flags_type    flags,          // flags
  input wire isw_pkg::isw_cell_ctl_type cell_ctl,       // cell control
  input wire logic [TMR_W-1:0]          timer_count_reg // count
);
  // ==========================================
  // single domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_push; $rose(vector_req) |-> stack_push && stack_data == $past(return_pc); endproperty
  a_push: assert property (p_push) else $error("push missing");
  property p_push1; stack_push |=> !stack_push; endproperty
  a_push1: assert property (p_push1) else $error("push too long");
  property p_hold; vector_req && !vector_ack |=> vector_req; endproperty
  a_hold: assert property (p_hold) else $error("vector dropped");
  property p_gie; $rose(vector_req) |-> $past(enables.global_irq_enable); endproperty
  a_gie: assert property (p_gie) else $error("vector without global enable");
  property p_ext;
    (option.ext_edge_select ? $rose(ext_irq_pin) : $fell(ext_irq_pin)) |-> ##[2:6] flags.ext_pin_irq_flag;
  endproperty
  a_ext: assert property (p_ext) else $error("pin edge lost");
  property p_wrap;
    (timer_count_reg == isw_pkg::TMR_WRAP && !timer_we) ##1 (timer_count_reg == isw_pkg::TMR_ZERO)
      |-> ##[0:1] flags.timer_overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");
  property p_tclr; $fell(flags.timer_overflow_flag) |-> $past(flag_clear.timer_overflow_flag); endproperty
  a_tclr: assert property (p_tclr) else $error("overflow flag cleared by itself");
  property p_frz; sleeping && $past(sleeping) |-> $stable(timer_count_reg); endproperty
  a_frz: assert property (p_frz) else $error("timer ran in sleep");
  property p_cell;
    cell_ctl.cell_on && ((cell_ctl.cell_rise_irq_enable && $rose(cell_out))
      || (cell_ctl.cell_fall_irq_enable && $fell(cell_out))) |=> flags.cell_irq_flag;
  endproperty
  a_cell: assert property (p_cell) else $error("cell edge lost");
  property p_keep; flags.cell_irq_flag && !flag_clear.cell_irq_flag |=> flags.cell_irq_flag; endproperty
  a_keep: assert property (p_keep) else $error("cell flag lost");
  property p_rst; disable iff (1'b0) rst |-> cell_ctl == isw_pkg::CELL_CTL_RESET; endproperty
  a_rst: assert property (p_rst) else $error("cell control not cleared");
endmodule
bind isw_irq_wake isw_irq_wake_asserts #(.TMR_W(TMR_W)) u_chk (.clk_sys, .rst, .ext_irq_pin, .cell_out,
  .enables, .option, .flag_clear, .timer_we, .vector_ack, .return_pc, .sleeping, .vector_req,
  .stack_push, .stack_data, .flags, .cell_ctl, .timer_count_reg);

/* File: dv/tb_isw_irq_wake.sv */
// testbench: directed scenarios for the interrupt and wake block
`timescale 1ns/10ps
module tb_isw_irq_wake;
  // ==========================================
  // signals
  logic clk_sys = 1'b0, rst = 1'b0, ack_slow = 1'b0;             // clock, reset, core pace
  logic q2_phase, q4_phase, vector_ack;                           // from core model
  logic ext_irq_pin = 1'b0, timer_ext_clock_in = 1'b0;            // pins
  logic cell_out = 1'b0, cell_ctl_we = 1'b0, timer_we = 1'b0;     // strobes
  logic sleep_exec = 1'b0, instr_done = 1'b0;                     // core events
  logic [7:0] timer_wdata = 8'h00;                                // timer data
  logic [8:0] return_pc = 9'h000;                                 // resume address
  isw_pkg::isw_enables_type enables = '0;                         // enables
  isw_pkg::isw_option_type option = '0;                           // options
  isw_pkg::isw_cell_ctl_type cell_ctl_wdata = '0, cell_ctl;       // cell control
  isw_pkg::isw_flags_type flag_clear = '0, flags;                 // flags
  logic sleeping, wake_pulse, vector_req, stack_push;             // status
  logic [8:0] stack_data;                                         // pushed pc
  logic [7:0] timer_count_reg;                                    // count
  int mismatches = 0, checks = 0;                                 // tallies
  always #4 clk_sys = ~clk_sys;
  isw_irq_wake u_dut (.clk_sys, .rst, .q2_phase, .q4_phase, .ext_irq_pin, .timer_ext_clock_in, .cell_out,
    .enables, .option, .cell_ctl_wdata, .cell_ctl_we, .flag_clear, .timer_we, .timer_wdata, .sleep_exec,
    .instr_done, .vector_ack, .return_pc, .sleeping, .wake_pulse, .vector_req, .stack_push, .stack_data,
    .flags, .cell_ctl, .timer_count_reg);
  isw_core_model u_core (.clk_sys, .rst, .ack_slow, .vector_req, .q2_phase, .q4_phase, .vector_ack);
  // ==========================================
  // helpers; inputs move on falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step; // one retired instruction
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
  endtask
  task automatic clr; // clear all flags
    flag_clear = 3'h7;
    cyc(1);
    flag_clear = 3'h0;
  endtask
  task automatic wr_cell(input logic [2:0] v);
    cell_ctl_wdata = v;
    cell_ctl_we = 1'b1;
    cyc(1);
    cell_ctl_we = 1'b0;
  endtask
  task automatic wr_tmr(input logic [7:0] v);
    timer_wdata = v;
    timer_we = 1'b1;
    cyc(1);
    timer_we = 1'b0;
  endtask
  task automatic take_vec; // right after step
    chk({vector_req, stack_push, stack_data}, {2'b11, return_pc});
    cyc(1);
    chk(stack_push, 0);
    for (int i = 0; i < 20 && vector_req; i++) cyc(1);
    chk(vector_req, 0);
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    wr_cell(3'h7);
    chk(cell_ctl, 3'h7);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk({sleeping, vector_req, stack_push, flags, cell_ctl, timer_count_reg}, 0);
  endtask
  task automatic t_ext; // both edge selects, prompt and slow core
    enables = 5'b10100;
    for (int s = 0; s < 2; s++) begin
      option.ext_edge_select = s[0];
      ext_irq_pin = s[0];
      cyc(8);
      clr;
      ext_irq_pin = ~s[0]; // wrong edge
      cyc(8);
      chk(flags.ext_pin_irq_flag, 0);
      ext_irq_pin = s[0];
      cyc(8);
      chk(flags.ext_pin_irq_flag, 1);
      ack_slow = s[0];
      return_pc = {s[0], 8'h5a};
      step;
      take_vec;
      clr;
    end
  endtask
  task automatic t_timer;
    int n;
    logic [7:0] v;
    option.prescaler_assign = 1'b1;
    wr_tmr(8'hfc);
    for (n = 0; n < 100 && timer_count_reg != 8'h00; n++) cyc(1);
    cyc(1);
    chk(flags.timer_overflow_flag, 1);
    cyc(40);
    chk(flags.timer_overflow_flag, 1);
    clr;
    chk(flags.timer_overflow_flag, 0);
    option.prescaler_assign = 1'b0;
    for (int s = 0; s < 8; s++) begin // measure q4 pulses per step
      option.prescale_select = s[2:0];
      wr_tmr(8'h00);
      chk(timer_count_reg, 0);
      for (int k = 0; k < 2; k++) begin
        v = timer_count_reg;
        n = 0;
        for (int i = 0; i < 1200 && timer_count_reg == v; i++) begin
          n += int'(q4_phase);
          cyc(1);
        end
      end
      chk(n, 2 << s);
    end
    option.prescaler_assign = 1'b1;
    option.counter_mode = 1'b1;
    wr_tmr(8'h00);
    repeat (3) begin
      timer_ext_clock_in = 1'b1;
      cyc(8);
      timer_ext_clock_in = 1'b0;
      cyc(8);
    end
    chk(timer_count_reg, 3);
    option.counter_mode = 1'b0;
    clr;
  endtask
  task automatic t_cell;
    for (int m = 1; m < 4; m++) begin // each edge enable mix with at least one set
      wr_cell({1'b1, m[1:0]});
      cell_out = 1'b1;
      cyc(2);
      chk(flags.cell_irq_flag, m[1]);
      clr;
      cell_out = 1'b0;
      cyc(2);
      chk(flags.cell_irq_flag, m[0]);
      clr;
    end
    flag_clear.cell_irq_flag = 1'b1; // edge lands on the clear
    cell_out = 1'b1;
    cyc(1);
    flag_clear = 3'h0;
    cyc(1);
    chk(flags.cell_irq_flag, 1);
    enables = 5'b11001;
    clr;
    wr_cell(3'h3); // cell off
    cell_out = 1'b0;
    cyc(2);
    step;
    chk(vector_req, 0);
    wr_cell(3'h7);
    cell_out = 1'b1;
    cyc(2);
    step;
    take_vec;
    cell_out = 1'b0;
    cyc(2);
    clr;
  endtask
  task automatic t_sleep;
    logic [7:0] v;
    option.ext_edge_select = 1'b1;
    ext_irq_pin = 1'b0;
    for (int g = 0; g < 2; g++) begin // without and with global enable
      enables = {g[0], 4'b0110};
      cyc(8);
      clr;
      sleep_exec = 1'b1;
      cyc(1);
      sleep_exec = 1'b0;
      cyc(1);
      v = timer_count_reg;
      cyc(40);
      chk({sleeping, timer_count_reg}, {1'b1, v});
      ext_irq_pin = 1'b1;
      for (int i = 0; i < 20 && sleeping; i++) cyc(1);
      chk({sleeping, vector_req}, 0);
      step;
      chk(vector_req, g[0]);
      if (g == 1) take_vec;
      ext_irq_pin = 1'b0;
    end
    clr;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1; // a real rising edge, so the async reset acts at time zero
    cyc(2);
    rst = 1'b0;
    t_reset;
    t_ext;
    t_timer;
    t_cell;
    t_sleep;
    end_sim;
  end
  initial begin
    #240000;
    mismatches++;
    end_sim;
  end
endmodule
